// ===== xbdec_defines.svh
/*
 Constants of the extension bus address decoder: window bases and ends,
 enable bit positions, flash sector bounds and reset values.
 Assumes 24-bit byte addresses from the CPU core.
*/
// Summary of operation
// - First extension RAM E000-E7FF decodes when global and bit 2 set.
// - Second RAM sits at the programmed range when global and bit 3 set.
// - Second RAM range goes external while the global enable is clear.
// - Second RAM resets to 09'0000-09'3FFF, mirrored per 16K to 0F'FFFF.
// - Extension RAM: 16-bit demultiplexed, no waits, bytes and words.
// - EF00-EFFF decodes to first CAN when global and bit 0 set.
// - EE00-EEFF decodes to second CAN when global and bit 1 set.
// - ED00-EDFF decodes to real-time clock when global and bit 4 set.
// - EC00-ECFF decodes to extra PWM when global and bit 6 set.
// - E900-E9FF decodes to second async serial when global and bit 7 set.
// - E800-E8FF decodes to second sync serial when global and bit 8 set.
// - EA00-EAFF decodes to I2C when global and bit 9 set.
// - EB00-EBFF decodes to misc features when global and bit 10 set.
// - Peripheral windows take word accesses only, with two wait states.
// - With any CAN in use only four segment address lines are given.
// - Disabled peripherals leave address space, pins and interrupts free.
// - After end of init, disabled peripherals lose clock, RAMs and misc kept.
// - No reset goes to gated peripherals after end of init.
// - User mode maps eight flash sectors; test sector hidden.
// - Bootstrap mode shows the 8K test sector at 00'0000.
`ifndef XBDEC_DEFINES_SVH
`define XBDEC_DEFINES_SVH
`define XBDEC_RAM1_BASE 24'h00e000
`define XBDEC_RAM1_END 24'h00e7ff
`define XBDEC_CAN1_PAGE 16'h00ef
`define XBDEC_CAN2_PAGE 16'h00ee
`define XBDEC_RTC_PAGE 16'h00ed
`define XBDEC_PWM_PAGE 16'h00ec
`define XBDEC_MISC_PAGE 16'h00eb
`define XBDEC_I2C_PAGE 16'h00ea
`define XBDEC_ASC_PAGE 16'h00e9
`define XBDEC_SSC_PAGE 16'h00e8
`define XBDEC_EN_CAN1 0
`define XBDEC_EN_CAN2 1
`define XBDEC_EN_RAM1 2
`define XBDEC_EN_RAM2 3
`define XBDEC_EN_RTC 4
`define XBDEC_EN_PWM 6
`define XBDEC_EN_ASC 7
`define XBDEC_EN_SSC 8
`define XBDEC_EN_I2C 9
`define XBDEC_EN_MISC 10
`define XBDEC_RAM2_RST_BASE 24'h090000
`define XBDEC_RAM2_RST_TOP 24'h0fffff
`define XBDEC_RAM2_MASK 24'h003fff
`define XBDEC_FL_LOW_END 24'h007fff
`define XBDEC_FL_HIGH_BASE 24'h018000
`define XBDEC_FL_HIGH_END 24'h04ffff
`define XBDEC_FL_TEST_END 24'h001fff
`define XBDEC_PERIPH_WAITS 2'h2
`define XBDEC_RAM_WAITS 2'h0
`define XBDEC_SEG_WITH_CAN 4'h4
`define XBDEC_SEG_FULL 4'h8
`endif

// ===== xbdec_pkg.sv
/*
 Types of the extension bus address decoder.
 Assumes nothing beyond the constants header.
*/
package xbdec_pkg;
    typedef enum logic [3:0] {
        XBDEC_T_EXT = 4'h0,
        XBDEC_T_FLASH = 4'h1,
        XBDEC_T_TFLASH = 4'h2,
        XBDEC_T_RAM1 = 4'h3,
        XBDEC_T_RAM2 = 4'h4,
        XBDEC_T_CAN1 = 4'h5,
        XBDEC_T_CAN2 = 4'h6,
        XBDEC_T_RTC = 4'h7,
        XBDEC_T_PWM = 4'h8,
        XBDEC_T_ASC = 4'h9,
        XBDEC_T_SSC = 4'ha,
        XBDEC_T_I2C = 4'hb,
        XBDEC_T_MISC = 4'hc
    } xbdec_target_t;

    typedef enum logic [1:0] {
        XBDEC_S_RESET = 2'b01,
        XBDEC_S_RUN = 2'b10
    } xbdec_init_t;
endpackage

// ===== xbdec_map.sv
/*
 Combinational address map: picks exactly one target for an address.
 Assumes enables are already stable on the same clock.
*/
`timescale 1ns/100ps
`include "xbdec_defines.svh"
`default_nettype none
module xbdec_map
    import xbdec_pkg::*;
(
    // Access.
    input wire logic [23:0] i_addr,
    // Enables.
    input wire logic i_global_en,
    input wire logic [10:0] i_periph_en,
    input wire logic i_boot_mode,
    input wire logic [23:0] i_ram2_base,
    // Result.
    output xbdec_target_t o_target
);
    function automatic logic page_hit(input logic [23:0] a,
                                      input logic [15:0] pg);
        page_hit = (a[23:8] == pg);
    endfunction

    logic [23:0] ram2_lim;
    assign ram2_lim = `XBDEC_RAM2_RST_TOP;

    // A priority chain guarantees one target per access.
    always_comb begin
        o_target = XBDEC_T_EXT;
        if (i_boot_mode && i_addr <= `XBDEC_FL_TEST_END) begin
            o_target = XBDEC_T_TFLASH;
        end else if (i_addr <= `XBDEC_FL_LOW_END ||
                     (i_addr >= `XBDEC_FL_HIGH_BASE &&
                      i_addr <= `XBDEC_FL_HIGH_END)) begin
            o_target = XBDEC_T_FLASH;
        end else if (i_global_en) begin
            if (i_periph_en[`XBDEC_EN_RAM1] && i_addr >= `XBDEC_RAM1_BASE
                && i_addr <= `XBDEC_RAM1_END) begin
                o_target = XBDEC_T_RAM1;
            end else if (i_periph_en[`XBDEC_EN_RAM2] &&
                         i_addr >= i_ram2_base && i_addr <= ram2_lim) begin
                o_target = XBDEC_T_RAM2;
            end else if (i_periph_en[`XBDEC_EN_CAN1] &&
                         page_hit(i_addr, `XBDEC_CAN1_PAGE)) begin
                o_target = XBDEC_T_CAN1;
            end else if (i_periph_en[`XBDEC_EN_CAN2] &&
                         page_hit(i_addr, `XBDEC_CAN2_PAGE)) begin
                o_target = XBDEC_T_CAN2;
            end else if (i_periph_en[`XBDEC_EN_RTC] &&
                         page_hit(i_addr, `XBDEC_RTC_PAGE)) begin
                o_target = XBDEC_T_RTC;
            end else if (i_periph_en[`XBDEC_EN_PWM] &&
                         page_hit(i_addr, `XBDEC_PWM_PAGE)) begin
                o_target = XBDEC_T_PWM;
            end else if (i_periph_en[`XBDEC_EN_ASC] &&
                         page_hit(i_addr, `XBDEC_ASC_PAGE)) begin
                o_target = XBDEC_T_ASC;
            end else if (i_periph_en[`XBDEC_EN_SSC] &&
                         page_hit(i_addr, `XBDEC_SSC_PAGE)) begin
                o_target = XBDEC_T_SSC;
            end else if (i_periph_en[`XBDEC_EN_I2C] &&
                         page_hit(i_addr, `XBDEC_I2C_PAGE)) begin
                o_target = XBDEC_T_I2C;
            end else if (i_periph_en[`XBDEC_EN_MISC] &&
                         page_hit(i_addr, `XBDEC_MISC_PAGE)) begin
                o_target = XBDEC_T_MISC;
            end
        end
    end
endmodule // xbdec_map
`default_nettype wire

// ===== xbdec_gate.sv
/*
 Clock enable and reset gating of the extension peripherals after end of
 initialisation. Assumes the end-of-init pulse comes from the CPU clock.
*/
`timescale 1ns/100ps
`include "xbdec_defines.svh"
`default_nettype none
module xbdec_gate
    import xbdec_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Control.
    input wire logic i_init_done,
    input wire logic [10:0] i_periph_en,
    // Gating.
    output logic [10:0] o_clk_en,
    output logic [10:0] o_periph_rst
);
    typedef struct packed {
        xbdec_init_t st;
        logic [10:0] clk_en;
        logic [10:0] prst;
    } xbdec_gate_state_t;

    xbdec_gate_state_t r;
    xbdec_gate_state_t next_r;
    logic [10:0] keep;

    // RAMs and the misc block always keep their clock.
    assign keep = (11'h1 << `XBDEC_EN_RAM1) | (11'h1 << `XBDEC_EN_RAM2) |
                  (11'h1 << `XBDEC_EN_MISC);

    always_comb begin
        next_r = r;
        case (r.st)
            XBDEC_S_RESET: begin
                next_r.clk_en = 11'h7ff;
                next_r.prst = 11'h7ff;
                if (i_init_done) begin
                    next_r.st = XBDEC_S_RUN;
                end
            end
            XBDEC_S_RUN: begin
                next_r.clk_en = i_periph_en | keep;
                next_r.prst = 11'h000;
            end
            default: next_r.st = XBDEC_S_RESET;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '{st: XBDEC_S_RESET, clk_en: 11'h7ff, prst: 11'h7ff};
        end else begin
            r <= next_r;
        end
    end

    assign o_clk_en = r.clk_en;
    assign o_periph_rst = r.prst;

    sequence run_twice;
        r.st == XBDEC_S_RUN ##1 r.st == XBDEC_S_RUN;
    endsequence

    chk_gate_stops: assert property (
        @(posedge i_clk) disable iff (i_rst)
        run_twice |-> o_clk_en == ($past(i_periph_en) | keep))
        else $error("Disabled peripheral still clocked.");
    chk_gate_norst: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $past(r.st) == XBDEC_S_RUN |-> o_periph_rst == 11'h000)
        else $error("Reset raised after end of init.");
endmodule // xbdec_gate
`default_nettype wire

// ===== xbdec_top.sv
/*
 Extension bus address decoder and peripheral gating. Registers the target
 of each CPU access and reports its bus timing.
 Assumes the CPU holds enables stable between accesses.
*/
`timescale 1ns/100ps
`include "xbdec_defines.svh"
`default_nettype none
module xbdec_top
    import xbdec_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RST,
    // Access from the CPU.
    input wire logic I_REQ,
    input wire logic [23:0] I_ADDR,
    input wire logic I_BYTE,
    // Configuration.
    input wire logic I_XBUS_GLOBAL_ENABLE,
    input wire logic [10:0] I_PERIPH_ENABLE_REG,
    input wire logic [23:0] I_SECOND_RAM_RANGE_SELECT,
    input wire logic I_RANGE_LOAD,
    input wire logic I_BOOT_MODE,
    input wire logic I_END_OF_INIT_INSTRUCTION,
    // Decode result.
    output logic O_VALID,
    output logic [3:0] O_TARGET,
    output logic O_EXTERNAL,
    output logic O_BYTE_ERR,
    output logic [1:0] O_WAITS,
    output logic O_DEMUX16,
    // Segment lines and gating.
    output logic [3:0] O_SEG_LINES,
    output logic [10:0] O_PERIPH_CLK_EN,
    output logic [10:0] O_PERIPH_RST
);
    typedef struct packed {
        logic [23:0] ram2_base;
        logic valid;
        xbdec_target_t tgt;
        logic berr;
        logic [1:0] waits;
        logic [3:0] seg;
    } xbdec_top_state_t;

    xbdec_top_state_t r;
    xbdec_top_state_t next_r;
    xbdec_target_t hit;
    logic [10:0] en_eff;
    logic is_periph;

    // Enables only count together with the global enable.
    assign en_eff = I_XBUS_GLOBAL_ENABLE ? I_PERIPH_ENABLE_REG : 11'h000;

    xbdec_map u_map (
        .i_addr(I_ADDR),
        .i_global_en(I_XBUS_GLOBAL_ENABLE),
        .i_periph_en(en_eff),
        .i_boot_mode(I_BOOT_MODE),
        .i_ram2_base(r.ram2_base),
        .o_target(hit)
    );

    xbdec_gate u_gate (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_init_done(I_END_OF_INIT_INSTRUCTION),
        .i_periph_en(en_eff),
        .o_clk_en(O_PERIPH_CLK_EN),
        .o_periph_rst(O_PERIPH_RST)
    );

    assign is_periph = (hit >= XBDEC_T_CAN1);

    always_comb begin
        next_r = r;
        next_r.valid = I_REQ;
        if (I_RANGE_LOAD) begin
            // Base is aligned to 16K so mirrors fall on 16K boundaries.
            next_r.ram2_base = I_SECOND_RAM_RANGE_SELECT &
                               ~`XBDEC_RAM2_MASK;
        end
        if (I_REQ) begin
            next_r.tgt = hit;
            // A byte access to a peripheral window is refused.
            next_r.berr = is_periph && I_BYTE;
            next_r.waits = is_periph ? `XBDEC_PERIPH_WAITS :
                                       `XBDEC_RAM_WAITS;
        end
        // Any enabled CAN cuts the segment lines from eight to four,
        // since the CAN pins share the segment port.
        next_r.seg = (en_eff[`XBDEC_EN_CAN1] || en_eff[`XBDEC_EN_CAN2]) ?
                     `XBDEC_SEG_WITH_CAN : `XBDEC_SEG_FULL;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            r <= '{ram2_base: `XBDEC_RAM2_RST_BASE, valid: 1'b0,
                   tgt: XBDEC_T_EXT, berr: 1'b0, waits: 2'h0,
                   seg: `XBDEC_SEG_FULL};
        end else begin
            r <= next_r;
        end
    end

    assign O_VALID = r.valid;
    assign O_TARGET = r.tgt;
    assign O_EXTERNAL = r.valid && (r.tgt == XBDEC_T_EXT);
    assign O_BYTE_ERR = r.valid && r.berr;
    assign O_WAITS = r.waits;
    assign O_DEMUX16 = r.valid && (r.tgt >= XBDEC_T_RAM1);
    assign O_SEG_LINES = r.seg;

    chk_ram1_off: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_REQ && !I_XBUS_GLOBAL_ENABLE && I_ADDR >= `XBDEC_RAM1_BASE &&
        I_ADDR <= `XBDEC_RAM1_END |=> O_EXTERNAL)
        else $error("First RAM range not external while disabled.");
    chk_ram1_on: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_REQ && I_XBUS_GLOBAL_ENABLE && I_PERIPH_ENABLE_REG[2] &&
        I_ADDR[23:11] == 13'h001c |=> O_TARGET == XBDEC_T_RAM1)
        else $error("First RAM not decoded.");
    chk_ram2_ext: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_REQ && !I_XBUS_GLOBAL_ENABLE && I_ADDR >= r.ram2_base &&
        I_ADDR <= `XBDEC_RAM2_RST_TOP |=> O_EXTERNAL)
        else $error("Second RAM range not external.");
    chk_can1_win: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_REQ && I_XBUS_GLOBAL_ENABLE && I_PERIPH_ENABLE_REG[0] &&
        I_ADDR[23:8] == 16'h00ef |=> O_TARGET == XBDEC_T_CAN1)
        else $error("First CAN not decoded.");
    chk_i2c_win: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_REQ && I_XBUS_GLOBAL_ENABLE && I_PERIPH_ENABLE_REG[9] &&
        I_ADDR[23:8] == 16'h00ea |=> O_TARGET == XBDEC_T_I2C)
        else $error("I2C not decoded.");
    chk_periph_waits: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        O_VALID && O_TARGET >= XBDEC_T_CAN1 |-> O_WAITS == 2'h2)
        else $error("Peripheral window without two wait states.");
    chk_ram_nowait: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        O_VALID && (O_TARGET == XBDEC_T_RAM1 || O_TARGET == XBDEC_T_RAM2)
        |-> O_WAITS == 2'h0 && !O_BYTE_ERR)
        else $error("Extension RAM access not zero wait.");
    chk_boot_test: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_REQ && I_BOOT_MODE && I_ADDR < 24'h002000 |=>
        O_TARGET == XBDEC_T_TFLASH)
        else $error("Test sector not visible in boot mode.");
    chk_seg_can: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        I_XBUS_GLOBAL_ENABLE && (I_PERIPH_ENABLE_REG[0] ||
        I_PERIPH_ENABLE_REG[1]) |=> O_SEG_LINES == 4'h4)
        else $error("Eight segment lines offered with a CAN in use.");
endmodule // xbdec_top
`default_nettype wire

// ===== xbdec_xperiph_model.sv
/*
 Model of the extension peripherals behind the decoder: it notes any
 access that reaches a peripheral whose clock has been stopped.
 Assumes the decoder reports each access by a one-cycle valid.
*/
`timescale 1ns/100ps
`default_nettype none
module xbdec_xperiph_model
    import xbdec_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Decoder outputs.
    input wire logic i_valid,
    input wire logic [3:0] i_target,
    input wire logic [10:0] i_clk_en,
    // Fault flag.
    output logic o_fault
);
    localparam int BITS [13] = '{0, 0, 0, 2, 3, 0, 1, 4, 6, 7, 8, 9, 10};

    // A stopped peripheral cannot answer, so a hit on it is a fault.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_fault <= 1'b0;
        end else if (i_valid && i_target >= 4'h3 && i_target <= 4'hc &&
                     !i_clk_en[BITS[i_target]]) begin
            o_fault <= 1'b1;
        end
    end
endmodule // xbdec_xperiph_model
`default_nettype wire

// ===== xbdec_top_tb_top.sv
/*
 Testbench of the extension bus decoder: drives accesses, queues the
 expected answers and compares them when the decoder answers.
 Assumes an answer one cycle after each request.
*/
`timescale 1ns/100ps
`default_nettype none
module xbdec_top_tb_top
    import xbdec_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic byte_acc = 1'b0;
    logic glob = 1'b0;
    logic rload = 1'b0;
    logic boot = 1'b0;
    logic end_of_init_instruction = 1'b0;
    logic [23:0] addr = 24'h000000;
    logic [23:0] rsel = 24'h090000;
    logic [10:0] en = 11'h000;
    logic valid, ext, berr, demux, dead;
    logic [3:0] target, seg;
    logic [1:0] waits;
    logic [10:0] clk_en, prst;
    logic [8:0] q [$];
    logic [23:0] ram2 = 24'h090000;
    logic [31:0] s = 32'h05e5;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [15:0] PG [8] = '{16'h00ef, 16'h00ee, 16'h00ed,
        16'h00ec, 16'h00e9, 16'h00e8, 16'h00ea, 16'h00eb};
    localparam int PB [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
    localparam logic [23:0] WIN [13] = '{24'h00e000, 24'h00e700,
        24'h090000, 24'h0fc000, 24'h00ef00, 24'h00ee00, 24'h00ed00,
        24'h00ec00, 24'h00e900, 24'h00e800, 24'h00ea00, 24'h00eb00,
        24'h018000};

    xbdec_top u_dut (.I_CLK(clk), .I_RST(rst), .I_REQ(req),
        .I_ADDR(addr), .I_BYTE(byte_acc), .I_XBUS_GLOBAL_ENABLE(glob),
        .I_PERIPH_ENABLE_REG(en), .I_SECOND_RAM_RANGE_SELECT(rsel),
        .I_RANGE_LOAD(rload), .I_BOOT_MODE(boot),
        .I_END_OF_INIT_INSTRUCTION(end_of_init_instruction), .O_VALID(valid),
        .O_TARGET(target), .O_EXTERNAL(ext), .O_BYTE_ERR(berr),
        .O_WAITS(waits), .O_DEMUX16(demux), .O_SEG_LINES(seg),
        .O_PERIPH_CLK_EN(clk_en), .O_PERIPH_RST(prst));

    xbdec_xperiph_model u_far (.i_clk(clk), .i_rst(rst),
        .i_valid(valid), .i_target(target), .i_clk_en(clk_en),
        .o_fault(dead));

    initial begin
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Flash wins over every extension window, as the map is fixed.
    function automatic logic [3:0] tgt(logic [23:0] a);
        if (boot && a <= 24'h001fff) return XBDEC_T_TFLASH;
        if (a <= 24'h007fff || (a >= 24'h018000 && a <= 24'h04ffff))
            return XBDEC_T_FLASH;
        if (!glob) return XBDEC_T_EXT;
        if (a >= 24'h00e000 && a <= 24'h00e7ff)
            return en[2] ? XBDEC_T_RAM1 : XBDEC_T_EXT;
        if (a >= ram2 && a <= 24'h0fffff)
            return en[3] ? XBDEC_T_RAM2 : XBDEC_T_EXT;
        for (int i = 0; i < 8; i++) begin
            if (a[23:8] == PG[i])
                return en[PB[i]] ? 4'(i + 5) : XBDEC_T_EXT;
        end
        return XBDEC_T_EXT;
    endfunction

    task automatic acc(input logic [23:0] a, input logic b);
        logic [3:0] t;
        t = tgt(a);
        @(negedge clk);
        req = 1'b1;
        addr = a;
        byte_acc = b;
        // Plain data cycles only: no stack, register bank or bit use.
        q.push_back({t, t >= 4'h5 ? 2'h2 : 2'h0, b && t >= 4'h5,
            t == 4'h0, t >= 4'h3});
    endtask

    task automatic idle(input int n);
        @(negedge clk);
        req = 1'b0;
        repeat (n) @(negedge clk);
    endtask

    task automatic cmp_acc(input logic [8:0] e, input logic [8:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD access %h expected %h seen %h", addr, e, g);
        end
    endtask

    task automatic cmp_vec(input string n, input logic [10:0] e,
                           input logic [10:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic batch();
        for (int i = 0; i < 13; i++) begin
            acc(WIN[i] | 24'(rnd() & 32'hff), 1'(rnd()));
        end
        acc(24'h00e7ff, 1'b1);
        acc(24'h008000, 1'b0);
        acc(24'h04ffff, 1'b0);
        acc(24'h00dfff, 1'b0);
        acc(24'h100000 | 24'(rnd() & 32'hfffff), 1'b0);
        idle(2);
    endtask

    always @(negedge clk) begin
        if (valid === 1'b1) begin
            if (q.size() == 0) begin
                cmp_vec("spare answer", 11'h000, 11'h001);
            end else begin
                cmp_acc(q.pop_front(), {target, waits, berr, ext, demux});
            end
        end
    end

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // The whole run is about 120 cycles; this ceiling leaves margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmp_vec("clock enables", 11'h7ff, clk_en);
        cmp_vec("resets", 11'h7ff, prst);
        cmp_vec("segment lines", 11'h008, {7'h00, seg});
        for (int k = 0; k < 4; k++) begin
            glob = (k != 3);
            en = (k == 0) ? 11'h7ff : (k == 1) ? 11'h000 : 11'(rnd());
            batch();
            cmp_vec("segment lines", (glob && (en[0] || en[1])) ? 11'h004 :
                    11'h008, {7'h00, seg});
        end
        glob = 1'b1;
        en = 11'h7ff;
        rsel = 24'h0c1234;
        rload = 1'b1;
        @(negedge clk);
        rload = 1'b0;
        ram2 = 24'h0c0000;
        acc(24'h0bffff, 1'b0);
        acc(24'h0c0000, 1'b1);
        acc(24'h0e4321, 1'b0);
        idle(1);
        boot = 1'b1;
        acc(24'h000100, 1'b0);
        acc(24'h001fff, 1'b1);
        acc(24'h018000, 1'b0);
        idle(1);
        boot = 1'b0;
        en = 11'(rnd());
        end_of_init_instruction = 1'b1;
        @(negedge clk);
        end_of_init_instruction = 1'b0;
        @(negedge clk);
        cmp_vec("clock enables", en | 11'h40c, clk_en);
        cmp_vec("resets", 11'h000, prst);
        batch();
        cmp_vec("stopped hit", 11'h000, {10'h000, dead});
        cmp_vec("left in queue", 11'h000, 11'(q.size()));
        print_verdict();
    end
endmodule // xbdec_top_tb_top
`default_nettype wire
